/* File: src/bdsp_consts.vh */
// Constants for the background debug serial port.
// Assumes inclusion by the port's design file only.
`ifndef BDSP_CONSTS_VH
`define BDSP_CONSTS_VH
// Serial packet: status/control bit plus 16 data bits
`define BDSP_PKT_BITS 5'h11
`define BDSP_PKT_LAST 5'h10
// Device answers, status/control bit first
`define BDSP_MSG_OK 17'h0FFFF
`define BDSP_MSG_RETRY 17'h10000
`define BDSP_MSG_TEA 17'h10001
`define BDSP_MSG_ILLEGAL 17'h1FFFF
// Command word fields
`define BDSP_OP_HI 15
`define BDSP_OP_LO 10
`define BDSP_DIR_BIT 8
`define BDSP_SZ_HI 7
`define BDSP_SZ_LO 6
`define BDSP_AD_BIT 3
// Operand sizes
`define BDSP_SZ_BYTE 2'h0
`define BDSP_SZ_WORD 2'h1
`define BDSP_SZ_LONG 2'h2
// Operation codes
`define BDSP_OP_NOP 6'h00
`define BDSP_OP_RST 6'h01
`define BDSP_OP_CREG_WR 6'h02
`define BDSP_OP_GO 6'h03
`define BDSP_OP_MEM_RD 6'h06
`define BDSP_OP_MEM_WR 6'h07
`define BDSP_OP_ADR_RD 6'h08
`define BDSP_OP_CALL 6'h09
`define BDSP_OP_CREG_RD 6'h0A
`define BDSP_OP_DMR_RD 6'h0B
`define BDSP_OP_DMR_WR 6'h0D
`define BDSP_OP_DUMP 6'h0E
`define BDSP_OP_FILL 6'h0F
`define BDSP_OP_ADR_WR 6'h10
// Program counter in control register numbering
`define BDSP_CREG_PC 12'h80F
// Processor status codes
`define BDSP_PST_STOPPED 4'hE
`define BDSP_PST_HALTED 4'hF
// Halt source codes
`define BDSP_HS_NONE 4'h0
`define BDSP_HS_FAULT 4'h1
`define BDSP_HS_HWBRK 4'h2
`define BDSP_HS_HALTI 4'h3
`define BDSP_HS_PIN 4'h4
// Config/status register fields
`define BDSP_CSR_HS_HI 27
`define BDSP_CSR_HS_LO 24
`define BDSP_CSR_UHE 20
// Register offsets
`define BDSP_ADDR_CSR 4'h0
`define BDSP_ADDR_STAT 4'h4
// Reset timing
`define BDSP_RST_WAIT 5'h10
`define BDSP_RST_BREAKPOINT_REQUEST_PIN 5'h08
// Resume kinds
`define BDSP_RK_NORMAL 2'h0
`define BDSP_RK_AFTER_STOP 2'h1
`define BDSP_RK_RESET_EXC 2'h2
`define BDSP_RK_LOADED_PC 2'h3
`endif

/* File: src/bdsp_top.v */
// Background debug port: halt control, status and serial channel.
// Assumes a core that pulses its events and honours halt/resume.
`timescale 1ns/100ps
`include "bdsp_consts.vh"

module bdsp_top (
	input wire aclk, // 40 MHz clock
	input wire aresetn, // Sync reset, active low
	input wire ce, // Clock enable
	input wire debug_serial_clock, // Serial clock pin
	input wire debug_serial_in, // Serial data pin
	output reg debug_serial_out, // Serial data out
	input wire breakpoint_request_pin_n, // Break pin, active low
	input wire reset_input_pin_n, // Reset pin, active low
	input wire [3:0] core_pst, // Core trace status
	input wire core_instr_sample, // Per-instruction sample
	input wire core_double_fault, // Fault-on-fault
	input wire core_hw_break, // Hardware breakpoint
	input wire core_halt_instr, // Halt instruction run
	input wire core_user_mode, // Core in user mode
	input wire core_stopped, // Core in stop mode
	output reg [3:0] processor_status_out, // Status pins
	output reg core_halted, // Halt the core
	output reg core_priv_violation, // Privilege trap pulse
	output reg core_resume, // Resume pulse
	output reg [1:0] core_resume_kind, // How to resume
	output reg mem_req, // Memory request
	output reg mem_write, // Memory write
	output reg [1:0] mem_size, // Memory size
	output reg [31:0] mem_addr, // Aligned address
	output reg [31:0] mem_wdata, // Write data
	input wire mem_ack, // Memory done
	input wire transfer_error_ack, // Memory bus error
	input wire [31:0] mem_rdata, // Read data
	output reg creg_req, // Core register request
	output reg creg_write, // Core register write
	output reg creg_ctrl, // 1 control, 0 addr/data
	output reg [11:0] creg_sel, // Register number
	output reg [31:0] creg_wdata, // Write data
	input wire creg_ack, // Core register done
	input wire [31:0] creg_rdata, // Read data
	input wire [3:0] s_axi_awaddr, // AXI write address
	input wire s_axi_awvalid, // AXI
	output reg s_axi_awready, // AXI
	input wire [31:0] s_axi_wdata, // AXI
	input wire [3:0] s_axi_wstrb, // AXI
	input wire s_axi_wvalid, // AXI
	output reg s_axi_wready, // AXI
	output reg [1:0] s_axi_bresp, // AXI
	output reg s_axi_bvalid, // AXI
	input wire s_axi_bready, // AXI
	input wire [3:0] s_axi_araddr, // AXI read address
	input wire s_axi_arvalid, // AXI
	output reg s_axi_arready, // AXI
	output reg [31:0] s_axi_rdata, // AXI
	output reg [1:0] s_axi_rresp, // AXI
	output reg s_axi_rvalid, // AXI
	input wire s_axi_rready // AXI
);

localparam ST_IDLE = 2'h0;
localparam ST_EXT = 2'h1;
localparam ST_EXEC = 2'h2;

////////////////////////////////////////////////////////////////////////
// Pin synchronisers; first stage read only by the second
reg [1:0] sclk_s, sdi_s, breakpoint_request_pin_s, rst_s;
reg sclk_d;
always @(posedge aclk) begin
	if (!aresetn) begin
		sclk_s <= 2'h0;
		sdi_s <= 2'h0;
		breakpoint_request_pin_s <= 2'h3;
		rst_s <= 2'h0;
		sclk_d <= 1'b0;
	end else if (ce) begin
		sclk_s <= {sclk_s[0], debug_serial_clock};
		sdi_s <= {sdi_s[0], debug_serial_in};
		breakpoint_request_pin_s <= {breakpoint_request_pin_s[0], breakpoint_request_pin_n};
		rst_s <= {rst_s[0], reset_input_pin_n};
		sclk_d <= sclk_s[1];
	end
end
// Serial clock acts as enable on its sampled rising edge
wire sclk_rise = sclk_s[1] & ~sclk_d;
wire breakpoint_request_pin = ~breakpoint_request_pin_s[1];

////////////////////////////////////////////////////////////////////////
// Serial shifter, full duplex
reg [4:0] bitcnt;
reg [15:0] rxs;
reg [15:0] txs;
reg [16:0] resp0, resp1;
reg [1:0] rcnt;
wire [16:0] out_word = (rcnt != 2'h0) ? resp0 : `BDSP_MSG_RETRY;
wire pkt_done = sclk_rise & (bitcnt == `BDSP_PKT_LAST);
// Bit 16 of the received packet drops out of the 16-bit word
wire [15:0] rx_word = {rxs[14:0], sdi_s[1]};
wire pkt_load = sclk_rise & (bitcnt == 5'h00);
always @(posedge aclk) begin
	if (!aresetn) begin
		bitcnt <= 5'h00;
		rxs <= 16'h0000;
		txs <= 16'h0000;
		debug_serial_out <= 1'b0;
	end else if (ce && sclk_rise) begin
		rxs <= rx_word;
		// Output moves only on an enabled edge, so only with clock high
		if (bitcnt == 5'h00) begin
			debug_serial_out <= out_word[16];
			txs <= out_word[15:0];
		end else begin
			debug_serial_out <= txs[15];
			txs <= {txs[14:0], 1'b0};
		end
		bitcnt <= pkt_done ? 5'h00 : bitcnt + 5'h01;
	end
end

////////////////////////////////////////////////////////////////////////
// Halt control
reg halted, stop_halt, reset_halt, pc_loaded, user_halt_enable;
reg [3:0] hsrc;
reg pend_pin, pend_hw;
reg [4:0] rst_cnt;
reg rst_win;
reg go_pulse;
wire rst_early = rst_win & (rst_cnt < `BDSP_RST_BREAKPOINT_REQUEST_PIN);
wire halti_ok = core_halt_instr & (~core_user_mode | user_halt_enable);
wire at_sample = core_instr_sample | (core_stopped & pend_pin);
reg [3:0] next_src;
// Pick the strongest cause present this cycle
always @* begin
	next_src = `BDSP_HS_NONE;
	if (core_double_fault)
		next_src = `BDSP_HS_FAULT;
	else if ((pend_hw | core_hw_break) & at_sample)
		next_src = `BDSP_HS_HWBRK;
	else if (halti_ok)
		next_src = `BDSP_HS_HALTI;
	else if ((pend_pin | breakpoint_request_pin) & at_sample)
		next_src = `BDSP_HS_PIN;
	else if (breakpoint_request_pin & rst_early)
		next_src = `BDSP_HS_PIN;
end
always @(posedge aclk) begin
	if (!aresetn) begin
		halted <= 1'b0;
		stop_halt <= 1'b0;
		reset_halt <= 1'b0;
		hsrc <= `BDSP_HS_NONE;
		pend_pin <= 1'b0;
		pend_hw <= 1'b0;
		rst_cnt <= 5'h00;
		rst_win <= 1'b0;
		core_priv_violation <= 1'b0;
		core_resume <= 1'b0;
		core_resume_kind <= `BDSP_RK_NORMAL;
		processor_status_out <= 4'h0;
		core_halted <= 1'b0;
	end else if (ce) begin
		core_priv_violation <= core_halt_instr & core_user_mode & ~user_halt_enable;
		core_resume <= 1'b0;
		// Reset pin held: restart the post-reset wait
		if (!rst_s[1]) begin
			rst_cnt <= 5'h00;
			rst_win <= 1'b1;
		end else if (rst_win && !halted) begin
			rst_cnt <= rst_cnt + 5'h01;
			if (rst_cnt == `BDSP_RST_WAIT - 5'h01) begin
				rst_win <= 1'b0;
				core_resume <= 1'b1;
				core_resume_kind <= `BDSP_RK_RESET_EXC;
			end
		end
		if (!halted) begin
			pend_pin <= (pend_pin | breakpoint_request_pin) & ~at_sample;
			pend_hw <= (pend_hw | core_hw_break) & ~at_sample;
			if (next_src != `BDSP_HS_NONE) begin
				halted <= 1'b1;
				hsrc <= next_src;
				stop_halt <= core_stopped;
				reset_halt <= rst_early;
				rst_win <= 1'b0;
			end
		end else if (go_pulse) begin
			halted <= 1'b0;
			core_resume <= 1'b1;
			if (reset_halt)
				core_resume_kind <= pc_loaded ? `BDSP_RK_LOADED_PC :
					`BDSP_RK_RESET_EXC;
			else if (stop_halt)
				core_resume_kind <= `BDSP_RK_AFTER_STOP;
			else
				core_resume_kind <= `BDSP_RK_NORMAL;
			pend_pin <= 1'b0;
			pend_hw <= 1'b0;
		end
		core_halted <= halted;
		// Halted wins over stopped and core trace
		if (halted)
			processor_status_out <= `BDSP_PST_HALTED;
		else if (core_stopped)
			processor_status_out <= `BDSP_PST_STOPPED;
		else
			processor_status_out <= core_pst;
	end
end

////////////////////////////////////////////////////////////////////////
// Command engine
reg [1:0] state;
reg [15:0] cmd;
reg [63:0] ext;
reg [2:0] need;
reg blk_rd, blk_wr;
reg [31:0] blk_addr;
reg [1:0] blk_size;
wire [5:0] op = cmd[`BDSP_OP_HI:`BDSP_OP_LO];
wire [5:0] nop = rx_word[`BDSP_OP_HI:`BDSP_OP_LO];
wire [1:0] nsz = rx_word[`BDSP_SZ_HI:`BDSP_SZ_LO];
wire nlong = (nsz == `BDSP_SZ_LONG);
wire [1:0] csz = cmd[`BDSP_SZ_HI:`BDSP_SZ_LO];
wire clong = (csz == `BDSP_SZ_LONG);
wire [31:0] ext_data = clong ? ext[31:0] : {16'h0000, ext[15:0]};
wire [31:0] csr_val = {4'h0, hsrc, 3'h0, user_halt_enable, 20'h00000};
reg [2:0] next_need;
// Extension words expected after each command word
always @* begin
	case (nop)
	`BDSP_OP_MEM_RD: next_need = 3'h2;
	`BDSP_OP_MEM_WR: next_need = nlong ? 3'h4 : 3'h3;
	`BDSP_OP_FILL: next_need = nlong ? 3'h2 : 3'h1;
	`BDSP_OP_CREG_RD: next_need = 3'h2;
	`BDSP_OP_CREG_WR: next_need = 3'h4;
	`BDSP_OP_DMR_WR: next_need = 3'h2;
	`BDSP_OP_ADR_WR: next_need = 3'h2;
	default: next_need = 3'h0;
	endcase
end
// Line up a returned value: two words for long, one otherwise
task push_data;
	input [31:0] v;
	input lng;
	begin
		resp0 <= lng ? {1'b0, v[31:16]} : {1'b0, v[15:0]};
		resp1 <= {1'b0, v[15:0]};
		rcnt <= lng ? 2'h2 : 2'h1;
	end
endtask
task push_msg;
	input [16:0] m;
	begin
		resp0 <= m;
		rcnt <= 2'h1;
	end
endtask
// Start the action of a fully received command
task launch;
	input [5:0] o;
	begin
		state <= ST_EXEC;
		case (o)
		`BDSP_OP_MEM_RD, `BDSP_OP_MEM_WR, `BDSP_OP_FILL: begin
			mem_req <= 1'b1;
		end
		`BDSP_OP_ADR_WR, `BDSP_OP_CREG_RD, `BDSP_OP_CREG_WR: begin
			creg_req <= 1'b1;
		end
		`BDSP_OP_DUMP, `BDSP_OP_ADR_RD: begin
			// Request waits until address and register number settle
			state <= ST_EXEC;
		end
		`BDSP_OP_GO: begin
			go_pulse <= 1'b1;
			push_msg(`BDSP_MSG_OK);
			state <= ST_IDLE;
		end
		`BDSP_OP_DMR_RD: begin
			push_data(csr_val, 1'b1);
			state <= ST_IDLE;
		end
		`BDSP_OP_DMR_WR: begin
			if (cmd[3:0] == 4'h0)
				user_halt_enable <= ext[`BDSP_CSR_UHE];
			push_msg(`BDSP_MSG_OK);
			state <= ST_IDLE;
		end
		default: state <= ST_IDLE;
		endcase
	end
endtask
// Memory address forced to the operand size
function [31:0] align;
	input [31:0] a;
	input [1:0] s;
	begin
		if (s == `BDSP_SZ_LONG)
			align = {a[31:2], 2'h0};
		else if (s == `BDSP_SZ_WORD)
			align = {a[31:1], 1'b0};
		else
			align = a;
	end
endfunction
wire needs_halt = (nop == `BDSP_OP_ADR_RD) | (nop == `BDSP_OP_ADR_WR) |
	(nop == `BDSP_OP_CREG_RD) | (nop == `BDSP_OP_CREG_WR) |
	(nop == `BDSP_OP_GO) | (nop == `BDSP_OP_DMR_WR);
wire known = (nop == `BDSP_OP_NOP) | (nop == `BDSP_OP_MEM_RD) |
	(nop == `BDSP_OP_MEM_WR) | (nop == `BDSP_OP_DMR_RD) | needs_halt |
	(nop == `BDSP_OP_DUMP) | (nop == `BDSP_OP_FILL);
reg axi_uhe_we;
reg axi_uhe_val;
always @(posedge aclk) begin
	if (!aresetn) begin
		state <= ST_IDLE;
		cmd <= 16'h0000;
		ext <= 64'h0;
		need <= 3'h0;
		resp0 <= `BDSP_MSG_RETRY;
		resp1 <= `BDSP_MSG_RETRY;
		rcnt <= 2'h0;
		blk_rd <= 1'b0;
		blk_wr <= 1'b0;
		blk_addr <= 32'h0;
		blk_size <= `BDSP_SZ_BYTE;
		mem_req <= 1'b0;
		mem_write <= 1'b0;
		mem_size <= `BDSP_SZ_BYTE;
		mem_addr <= 32'h0;
		mem_wdata <= 32'h0;
		creg_req <= 1'b0;
		creg_write <= 1'b0;
		creg_ctrl <= 1'b0;
		creg_sel <= 12'h000;
		creg_wdata <= 32'h0;
		go_pulse <= 1'b0;
		pc_loaded <= 1'b0;
		user_halt_enable <= 1'b0;
	end else if (ce) begin
		go_pulse <= 1'b0;
		if (axi_uhe_we)
			user_halt_enable <= axi_uhe_val;
		if (go_pulse)
			pc_loaded <= 1'b0;
		// Pop the answer now on its way out
		if (pkt_load && rcnt != 2'h0) begin
			resp0 <= resp1;
			rcnt <= rcnt - 2'h1;
		end
		case (state)
		ST_IDLE: if (pkt_done) begin
			cmd <= rx_word;
			need <= next_need;
			if (!known)
				push_msg(`BDSP_MSG_ILLEGAL);
			else if ((nop == `BDSP_OP_DUMP && !blk_rd) ||
				(nop == `BDSP_OP_FILL && !blk_wr))
				push_msg(`BDSP_MSG_ILLEGAL);
			else if (needs_halt && !halted)
				push_msg(`BDSP_MSG_RETRY);
			else if (nop != `BDSP_OP_NOP) begin
				// Drop stale answers first so a quick command keeps its own
				rcnt <= 2'h0;
				if (next_need != 3'h0)
					state <= ST_EXT;
				else
					launch(nop);
			end
		end
		ST_EXT: if (pkt_done) begin
			ext <= {ext[47:0], rx_word};
			need <= need - 3'h1;
		end else if (need == 3'h0) begin
			// Pick up address and data from the extension words
			mem_write <= ~cmd[`BDSP_DIR_BIT];
			mem_size <= csz;
			mem_wdata <= ext_data;
			creg_write <= ~cmd[`BDSP_DIR_BIT];
			creg_ctrl <= (op == `BDSP_OP_CREG_RD) | (op == `BDSP_OP_CREG_WR);
			creg_sel <= (op == `BDSP_OP_CREG_RD) ? ext[11:0] :
				(op == `BDSP_OP_CREG_WR) ? ext[43:32] :
				{8'h00, cmd[`BDSP_AD_BIT:0]};
			creg_wdata <= ext[31:0];
			if (op == `BDSP_OP_FILL) begin
				mem_addr <= align(blk_addr, blk_size);
				mem_size <= blk_size;
			end else if (op == `BDSP_OP_MEM_WR)
				mem_addr <= align(clong ? ext[63:32] : ext[47:16], csz);
			else
				mem_addr <= align(ext[31:0], csz);
			launch(op);
		end
		ST_EXEC: begin
			if (op == `BDSP_OP_DUMP || op == `BDSP_OP_ADR_RD) begin
				// Settle dump address and register number first
				mem_addr <= align(blk_addr, blk_size);
				mem_size <= blk_size;
				mem_write <= 1'b0;
				creg_write <= 1'b0;
				creg_ctrl <= 1'b0;
				creg_sel <= {8'h00, cmd[`BDSP_AD_BIT:0]};
				mem_req <= (op == `BDSP_OP_DUMP);
				creg_req <= (op == `BDSP_OP_ADR_RD);
				cmd[`BDSP_OP_HI:`BDSP_OP_LO] <= (op == `BDSP_OP_DUMP) ?
					`BDSP_OP_MEM_RD : `BDSP_OP_CREG_RD;
			end else if (mem_req && (mem_ack || transfer_error_ack)) begin
				mem_req <= 1'b0;
				state <= ST_IDLE;
				blk_rd <= ~mem_write;
				blk_wr <= mem_write;
				blk_size <= mem_size;
				blk_addr <= mem_addr + ((mem_size == `BDSP_SZ_LONG) ? 32'h4 :
					(mem_size == `BDSP_SZ_WORD) ? 32'h2 : 32'h1);
				if (transfer_error_ack)
					push_msg(`BDSP_MSG_TEA);
				else if (mem_write)
					push_msg(`BDSP_MSG_OK);
				else if (mem_size == `BDSP_SZ_BYTE)
					push_data({24'h000000, mem_rdata[7:0]}, 1'b0);
				else
					push_data(mem_rdata, mem_size == `BDSP_SZ_LONG);
			end else if (creg_req && creg_ack) begin
				creg_req <= 1'b0;
				state <= ST_IDLE;
				if (creg_write && creg_ctrl && creg_sel == `BDSP_CREG_PC)
					pc_loaded <= 1'b1;
				if (creg_write)
					push_msg(`BDSP_MSG_OK);
				else
					push_data(creg_rdata, 1'b1);
			end
		end
		default: state <= ST_IDLE;
		endcase
	end
end

////////////////////////////////////////////////////////////////////////
// AXI4-Lite slave; address and data taken in either order
reg aw_have, w_have;
reg [3:0] aw_addr;
reg [31:0] w_data;
reg w_lane2;
always @(posedge aclk) begin
	if (!aresetn) begin
		aw_have <= 1'b0;
		w_have <= 1'b0;
		aw_addr <= 4'h0;
		w_data <= 32'h0;
		w_lane2 <= 1'b0;
		axi_uhe_we <= 1'b0;
		axi_uhe_val <= 1'b0;
		s_axi_awready <= 1'b0;
		s_axi_wready <= 1'b0;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= 2'h0;
		s_axi_arready <= 1'b0;
		s_axi_rvalid <= 1'b0;
		s_axi_rresp <= 2'h0;
		s_axi_rdata <= 32'h0;
	end else if (ce) begin
		axi_uhe_we <= 1'b0;
		s_axi_awready <= ~aw_have & ~s_axi_awready & s_axi_awvalid;
		s_axi_wready <= ~w_have & ~s_axi_wready & s_axi_wvalid;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_have <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_have <= 1'b1;
			w_data <= s_axi_wdata;
			w_lane2 <= s_axi_wstrb[2];
		end
		if (aw_have && w_have && !s_axi_bvalid) begin
			aw_have <= 1'b0;
			w_have <= 1'b0;
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= 2'h0;
			if (aw_addr == `BDSP_ADDR_CSR) begin
				axi_uhe_we <= w_lane2;
				axi_uhe_val <= w_data[`BDSP_CSR_UHE];
			end else if (aw_addr != `BDSP_ADDR_STAT)
				s_axi_bresp <= 2'h2;
		end else if (s_axi_bvalid && s_axi_bready)
			s_axi_bvalid <= 1'b0;
		s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready & s_axi_arvalid;
		if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= 2'h0;
			if (s_axi_araddr == `BDSP_ADDR_CSR)
				s_axi_rdata <= csr_val;
			else if (s_axi_araddr == `BDSP_ADDR_STAT)
				s_axi_rdata <= {28'h0, reset_halt, pc_loaded, state != ST_IDLE, halted};
			else begin
				s_axi_rdata <= 32'h0;
				s_axi_rresp <= 2'h2;
			end
		end else if (s_axi_rvalid && s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end
end

endmodule

/* File: tb/bdsp_monitor.sv */
// Checker for the debug port, watching the top ports only.
// Assumes a single aclk domain with synchronous active-low reset.
`timescale 1ns/100ps
module bdsp_monitor (
	input wire aclk, // Clock
	input wire aresetn, // Reset, active low
	input wire debug_serial_clock, // Serial clock pin
	input wire debug_serial_out, // Serial data out
	input wire core_halt_instr, // Halt instruction
	input wire core_user_mode, // User mode
	input wire core_priv_violation, // Trap pulse
	input wire core_halted, // Halted level
	input wire [3:0] processor_status_out, // Status pins
	input wire mem_req, // Memory request
	input wire [1:0] mem_size, // Memory size
	input wire [31:0] mem_addr, // Memory address
	input wire creg_req // Register request
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	////////////////////////////////////////////////////////////////////////////////
	// Output bit may only move during the clock's high phase
	serial_out_timing_a: assert property ($changed(debug_serial_out) |-> debug_serial_clock)
		else $error("serial out moved with clock low");
	// Settled halt always shows the halted code
	halt_status_a: assert property (core_halted && $past(core_halted) |-> processor_status_out == 4'hF)
		else $error("halted without halted status code");
	// Supervisor halt instruction stops the core promptly
	halt_instr_a: assert property (core_halt_instr && !core_user_mode |-> ##[1:4] core_halted)
		else $error("halt instruction did not halt");
	// Supervisor halt instruction never traps
	no_trap_a: assert property (core_halt_instr && !core_user_mode |=> !core_priv_violation [*3])
		else $error("privilege trap in supervisor mode");
	// Alignment is forced, so low address bits must be clear
	long_align_a: assert property (mem_req && mem_size == 2'h2 |-> mem_addr[1:0] == 2'h0)
		else $error("long access not aligned");
	word_align_a: assert property (mem_req && mem_size == 2'h1 |-> mem_addr[0] == 1'b0)
		else $error("word access not aligned");
	size_legal_a: assert property (mem_req |-> mem_size != 2'h3)
		else $error("reserved size on memory bus");
	// Core registers are touched only while halted
	creg_halted_a: assert property (creg_req |-> core_halted)
		else $error("register access while running");
endmodule

bind bdsp_top bdsp_monitor bdsp_monitor_inst (.*);

/* File: tb/bdsp_host.sv */
// Serial host model: masters the debug link with 17-bit packets.
// Assumes the device samples the link with its own faster clock.
`timescale 1ns/100ps
module bdsp_host (
	output logic sclk, // Serial clock to device
	output logic sdi, // Serial data to device
	input wire sdo // Serial data from device
);
	// Clock stands low outside frames
	initial begin
		sclk = 0;
		sdi = 0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// Full duplex packet, 200 ns per bit; reply read just before next rise
	task xfer(input logic [16:0] tx, output logic [16:0] rx);
		integer k;
		begin
			sdi = tx[16];
			#40;
			for (k = 16; k >= 0; k = k - 1) begin
				sclk = 1;
				#150 sclk = 0;
				#40 rx[k] = sdo;
				if (k > 0) sdi = tx[k - 1];
				#10;
			end
			sdi = ~sdi; // Released line must not echo the last bit
			#300;
		end
	endtask
endmodule

/* File: tb/bdsp_top_bench.sv */
// Bench for the debug port: serial host, AXI master, core and memory stubs.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/100ps
module bdsp_top_bench;
	logic aclk = 0, aresetn = 0, ce = 1, breakpoint_request_pin_n = 1, reset_input_pin_n = 0;
	logic debug_serial_clock, debug_serial_in, debug_serial_out, core_halted, core_resume;
	logic core_instr_sample = 0, core_double_fault = 0, core_hw_break = 0, core_halt_instr = 0;
	logic core_user_mode = 0, core_stopped = 0, mem_ack = 0, transfer_error_ack = 0, creg_ack = 0;
	logic core_priv_violation, mem_req, mem_write, creg_req, creg_write, creg_ctrl;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] core_resume_kind, mem_size, s_axi_bresp, s_axi_rresp, rkind, resp;
	logic [3:0] core_pst = 0, processor_status_out, s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [11:0] creg_sel;
	logic [31:0] mem_addr, mem_wdata, creg_wdata, s_axi_rdata, last_addr, rd, a;
	logic [31:0] mem_rdata = 0, creg_rdata = 0, s_axi_wdata = 0;
	logic [16:0] r;
	logic [15:0] ill [4] = '{16'h0400, 16'h2400, 16'h3980, 16'hFC00};
	logic [3:0] ev [4] = '{4'hF, 4'h7, 4'h3, 4'h1};
	integer seed = 29, num_errors = 0, comparisons = 0, i, pv = 0, tea_mode = 0, pv0, nres = 0;

	bdsp_top bdsp_top_inst (.*);
	bdsp_host bdsp_host_inst (.sclk(debug_serial_clock), .sdi(debug_serial_in), .sdo(debug_serial_out));

	always #12.5 aclk = ~aclk;
	////////////////////////////////////////////////////////////////////////////////
	// Memory and register stubs; random memory waits exercise the request hold, register acks come at once
	always @(posedge aclk) begin
		mem_ack <= 0;
		transfer_error_ack <= 0;
		creg_ack <= 0;
		core_pst <= $random(seed);
		if (mem_req && !mem_ack && !transfer_error_ack && $random(seed) % 2) begin
			mem_rdata <= $random(seed);
			last_addr <= mem_addr;
			if (tea_mode)
				transfer_error_ack <= 1;
			else
				mem_ack <= 1;
		end
		if (creg_req && !creg_ack) begin
			creg_ack <= 1;
			creg_rdata <= $random(seed);
		end
		if (core_resume) begin
			rkind <= core_resume_kind;
			nres <= nres + 1;
		end
		if (core_priv_violation) pv <= pv + 1;
	end
	////////////////////////////////////////////////////////////////////////////////
	task test_done;
		begin
			$display("errors %0d comparisons %0d", num_errors, comparisons);
			if (num_errors == 0 && comparisons > 0)
				$display("bench passed");
			else
				$display("bench failed");
			$finish;
		end
	endtask
	task check(input logic [31:0] s, input logic [31:0] e);
		begin
			comparisons = comparisons + 1;
			if (s !== e) begin
				num_errors = num_errors + 1;
				$display("mismatch at %0t seen %h expected %h", $time, s, e);
			end
		end
	endtask
	// Expected reply word of a sized read, high half first for long
	function logic [16:0] exp_word(input integer sz, input logic [31:0] d);
		exp_word = {1'b0, sz == 2 ? d[31:16] : d[15:0]};
	endfunction
	task ser(input logic [15:0] w);
		bdsp_host_inst.xfer({1'b0, w}, r);
	endtask
	// Poll with no-op until the device stops asking for a retry
	task poll;
		integer n;
		begin
			n = 0;
			do begin
				ser(16'h0);
				n = n + 1;
			end while (r === 17'h10000 && n < 40);
		end
	endtask
	task axw(input logic [3:0] ad, input logic [31:0] d);
		integer n;
		begin
			@(posedge aclk);
			s_axi_awaddr <= ad;
			s_axi_wdata <= d;
			s_axi_awvalid <= 1;
			s_axi_wvalid <= 1;
			s_axi_bready <= 1;
			n = 0;
			do begin
				@(posedge aclk);
				n = n + 1;
				if (s_axi_awready) s_axi_awvalid <= 0;
				if (s_axi_wready) s_axi_wvalid <= 0;
			end while (!s_axi_bvalid && n < 50);
			s_axi_bready <= 0;
		end
	endtask
	task axr(input logic [3:0] ad, output logic [31:0] d, output logic [1:0] e);
		integer n;
		begin
			@(posedge aclk);
			s_axi_araddr <= ad;
			s_axi_arvalid <= 1;
			s_axi_rready <= 1;
			n = 0;
			do begin
				@(posedge aclk);
				n = n + 1;
				if (s_axi_arready) s_axi_arvalid <= 0;
			end while (!s_axi_rvalid && n < 50);
			s_axi_rready <= 0;
			d = s_axi_rdata;
			e = s_axi_rresp;
		end
	endtask
	task pulse(input logic [3:0] e);
		begin
			@(posedge aclk);
			{core_double_fault, core_hw_break, core_halt_instr, core_instr_sample} <= e;
			@(posedge aclk);
			{core_double_fault, core_hw_break, core_halt_instr, core_instr_sample} <= 4'h0;
		end
	endtask
	task expect_halt(input logic [3:0] src);
		begin
			repeat (6) @(posedge aclk);
			check(core_halted, 1);
			check(processor_status_out, 4'hF);
			axr(4'h0, rd, resp);
			check(rd[27:24], src);
		end
	endtask
	task go(input logic [1:0] k);
		integer n0;
		begin
			n0 = nres;
			ser(16'h0C00);
			poll;
			check(r, 17'h0FFFF);
			repeat (10) @(posedge aclk);
			check(nres - n0, 1);
			check(rkind, k);
			check(core_halted, 0);
		end
	endtask
	// Reset pin pulse with the break pin held in the early window
	task rhalt;
		begin
			@(posedge aclk);
			reset_input_pin_n <= 0;
			repeat (4) @(posedge aclk);
			reset_input_pin_n <= 1;
			breakpoint_request_pin_n <= 0;
			repeat (4) @(posedge aclk);
			breakpoint_request_pin_n <= 1;
			repeat (20) @(posedge aclk);
			check(core_halted, 1);
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1;
		rhalt;
		axr(4'h4, rd, resp);
		check(rd[3:0], 4'h9);
		axr(4'h8, rd, resp);
		check(resp, 2'h2);
		check(rd, 32'h0);
		for (i = 0; i < 4; i = i + 1) begin
			ser(ill[i]);
			ser(16'h0);
			check(r, 17'h1FFFF);
		end
		go(2'h2);
		ser(16'h2180);
		ser(16'h0);
		check(r, 17'h10000);
		// Sized reads on odd addresses while the core runs
		for (i = 0; i < 3; i = i + 1) begin
			a = $random(seed) | 32'h3;
			ser(16'h1900 | (i << 6));
			ser(a[31:16]);
			ser(a[15:0]);
			poll;
			if (i == 0)
				check({r[16], r[7:0]}, {1'b0, mem_rdata[7:0]});
			else
				check(r, exp_word(i, mem_rdata));
			check(last_addr, a & (32'hFFFFFFFF << i));
			if (i == 2) begin
				ser(16'h0);
				check(r, exp_word(1, mem_rdata));
			end
		end
		// Dump carries on at the next longword after the long read
		ser(16'h3980);
		poll;
		check(last_addr, (a & 32'hFFFFFFFC) + 4);
		check(r, exp_word(2, mem_rdata));
		tea_mode = 1;
		ser(16'h1940);
		ser(16'h0);
		ser(16'h0);
		poll;
		check(r, 17'h10001);
		tea_mode = 0;
		// Word write to an odd address, then a fill of the next word
		a = $random(seed) | 32'h1;
		rd = $random(seed);
		ser(16'h1C40);
		ser(a[31:16]);
		ser(a[15:0]);
		ser(rd[15:0]);
		poll;
		check(r, 17'h0FFFF);
		check(last_addr, a & 32'hFFFFFFFE);
		check(mem_write, 1);
		check(mem_wdata, {16'h0000, rd[15:0]});
		ser(16'h3C40);
		ser(rd[31:16]);
		poll;
		check(r, 17'h0FFFF);
		check(last_addr, (a & 32'hFFFFFFFE) + 2);
		check(mem_wdata, {16'h0000, rd[31:16]});
		// User-mode halt traps until enabled
		core_user_mode <= 1;
		pv0 = pv;
		pulse(4'h3);
		repeat (6) @(posedge aclk);
		check(pv - pv0, 1);
		check(core_halted, 0);
		axw(4'h0, 32'h00100000);
		axr(4'h0, rd, resp);
		check(rd[20], 1);
		pulse(4'h3);
		expect_halt(4'h3);
		core_user_mode <= 0;
		ser(16'h2180);
		poll;
		check(r, exp_word(2, creg_rdata));
		ser(16'h0);
		check(r, exp_word(1, creg_rdata));
		go(2'h0);
		// Priority table, break pin pending in every row
		for (i = 0; i < 4; i = i + 1) begin
			breakpoint_request_pin_n <= 0;
			repeat (5) @(posedge aclk);
			check(core_halted, 0);
			pulse(ev[i]);
			breakpoint_request_pin_n <= 1;
			expect_halt(i + 1);
			go(2'h0);
		end
		// Loaded program counter after a reset halt
		rhalt;
		a = $random(seed);
		ser(16'h0880);
		ser(16'h0);
		ser(16'h080F);
		ser(a[31:16]);
		ser(a[15:0]);
		poll;
		check(r, 17'h0FFFF);
		check({creg_ctrl, creg_sel, creg_wdata}, {1'b1, 12'h80F, a});
		go(2'h3);
		test_done;
	end
	// Watchdog
	initial begin
		#2000000;
		num_errors = num_errors + 1;
		test_done;
	end
endmodule
